// ### design/rtc_timekeeper_alarm.sv
// Real-time clock top: bus slave, time, alarm, interrupts, oscillators
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper_alarm
    import rtc_pkg::*;
#(
    parameter int DETECT_LEN = DETECT_CYCLES
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  avAddress,
    input  wire logic        avRead,
    input  wire logic        avWrite,
    input  wire logic [31:0] avWriteData,
    output logic [31:0]      avReadData,
    output logic             avWaitrequest,
    input  wire logic        lowPowerOscIn,
    input  wire logic        powerDown,
    output logic             mainOscEnable,
    output logic             lowPowerOscEnable,
    output logic             extIntTick,
    output logic             extIntCyclic,
    output logic             extIntAlarm,
    output logic             wakeRequest,
    output logic             irq
);
    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    rtc_chain_if chain ();

    logic [6:0]  clockControl;
    logic [19:0] tickReload;
    logic [31:0] timeCount;
    logic [31:0] alarmValue;
    logic [31:0] cycleLength;
    logic [31:0] cycleCount;
    logic [2:0]  status;
    logic [2:0]  irqEnable;
    logic        matchPrev;
    logic [31:0] readMux;
    logic        wrAccept;
    logic        alarmMatch;
    logic        alarmEvent;
    logic        cycleEvent;
    logic [2:0]  events;
    logic [2:0]  clearMask;
    logic        run;
    logic        sleepStop;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    rtc_osc_detect #(
        .DETECT_LEN (DETECT_LEN)
    ) detector (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .lowPowerOscIn (lowPowerOscIn),
        .chain         (chain.detect)
    );

    rtc_tick_chain divider (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .chain   (chain.chain)
    );

    // ------------------------------------------------------------
    // Bus slave: one wait state, answer on second cycle
    // ------------------------------------------------------------
    assign wrAccept = avWrite & ~avWaitrequest;

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            avWaitrequest <= 1'b1;
        else if ((avRead | avWrite) & avWaitrequest)
            avWaitrequest <= 1'b0;
        else
            avWaitrequest <= 1'b1;
    end

    always_comb begin
        readMux = 32'h00000000;
        unique case (avAddress)
            OFS_CTRL: begin
                readMux[CTRL_W-1:0]   = clockControl;
                readMux[CTRL_SRC_LP]  = chain.lpSelect;
                readMux[CTRL_DETECTED] = chain.detectDone;
            end
            OFS_RELOAD:  readMux[DIV_W-1:0] = tickReload;
            OFS_TIME:    readMux = timeCount;
            OFS_ALARM:   readMux = alarmValue;
            OFS_CYCLE_N: readMux = cycleLength;
            // Low part of the long timer; time counter is the high part
            OFS_LONG_LO: readMux[25:0] = {chain.divValue, chain.preValue};
            OFS_STATUS:  readMux[EV_W-1:0] = status;
            OFS_IRQ_EN:  readMux[EV_W-1:0] = irqEnable;
            default:     readMux = 32'h00000000;
        endcase
    end

    // Read data stand only in the answer cycle, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            avReadData <= 32'h00000000;
        else if (avRead & avWaitrequest)
            avReadData <= readMux;
        else
            avReadData <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            clockControl <= CTRL_RESET;
        else if (wrAccept && avAddress == OFS_CTRL)
            clockControl <= avWriteData[CTRL_W-1:0];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            tickReload <= RELOAD_RESET;
        else if (wrAccept && avAddress == OFS_RELOAD)
            tickReload <= avWriteData[DIV_W-1:0];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            alarmValue <= 32'hFFFFFFFF;
        else if (wrAccept && avAddress == OFS_ALARM)
            alarmValue <= avWriteData;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            cycleLength <= 32'h00000000;
        else if (wrAccept && avAddress == OFS_CYCLE_N)
            cycleLength <= avWriteData;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            irqEnable <= 3'h0;
        else if (wrAccept && avAddress == OFS_IRQ_EN)
            irqEnable <= avWriteData[EV_W-1:0];
    end

    assign chain.reload = tickReload;

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    assign run       = clockControl[CTRL_RUN];
    // Idle does not stop the chain; power-down does unless kept running
    assign sleepStop = powerDown & ~clockControl[CTRL_RUN_SLEEP];

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            chain.countEn <= 1'b0;
        else
            chain.countEn <= run & chain.detectDone & ~sleepStop;
    end

    // ------------------------------------------------------------
    // Time counter: a software load beats a tick in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            timeCount <= 32'h00000000;
        else if (wrAccept && avAddress == OFS_TIME)
            timeCount <= avWriteData;
        else if (chain.tick)
            timeCount <= timeCount + 32'h00000001;
    end

    // ------------------------------------------------------------
    // Alarm compare, edge only so one match gives one event
    // ------------------------------------------------------------
    assign alarmMatch = (timeCount == alarmValue);
    assign alarmEvent = alarmMatch & ~matchPrev;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) matchPrev <= 1'b1;
        else        matchPrev <= alarmMatch;
    end

    // ------------------------------------------------------------
    // n-tick cycle counter; n of zero turns it off
    // ------------------------------------------------------------
    assign cycleEvent = chain.tick && cycleLength != 32'h00000000
                        && cycleCount + 32'h00000001 >= cycleLength;

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            cycleCount <= 32'h00000000;
        else if (wrAccept && avAddress == OFS_CYCLE_N)
            cycleCount <= 32'h00000000;
        else if (cycleEvent)
            cycleCount <= 32'h00000000;
        else if (chain.tick && cycleLength != 32'h00000000)
            cycleCount <= cycleCount + 32'h00000001;
    end

    // ------------------------------------------------------------
    // Sticky status, set wins over clear
    // ------------------------------------------------------------
    assign events = {cycleEvent, alarmEvent, chain.tick};

    always_comb begin
        clearMask = 3'h0;
        if (wrAccept && avAddress == OFS_CLEAR)
            clearMask = avWriteData[EV_W-1:0];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) status <= 3'h0;
        else        status <= (status & ~clearMask) | events;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) irq <= 1'b0;
        else        irq <= |(status & irqEnable);
    end

    // ------------------------------------------------------------
    // Port-2 external interrupt lines, one-cycle pulses
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            extIntTick   <= 1'b0;
            extIntCyclic <= 1'b0;
            extIntAlarm  <= 1'b0;
        end else begin
            extIntTick   <= chain.tick & clockControl[CTRL_ROUTE_TICK];
            extIntCyclic <= cycleEvent & clockControl[CTRL_ROUTE_CYCLE];
            extIntAlarm  <= alarmEvent & clockControl[CTRL_ROUTE_ALARM];
        end
    end

    // ------------------------------------------------------------
    // Wake from power-down, held until power-down ends or the wake bit is cleared
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            wakeRequest <= 1'b0;
        else if (!powerDown || !clockControl[CTRL_WAKE])
            wakeRequest <= 1'b0;
        else if (alarmEvent | cycleEvent)
            wakeRequest <= 1'b1;
    end

    // ------------------------------------------------------------
    // Oscillator management
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            mainOscEnable <= 1'b1;
        else if (!powerDown)
            mainOscEnable <= 1'b1;
        else if (chain.lpSelect)
            mainOscEnable <= 1'b0;
        else
            // Main source: kept for the clock unless disabled or told off
            mainOscEnable <= run & ~clockControl[CTRL_OSC_OFF];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            lowPowerOscEnable <= 1'b1;
        else if (!powerDown)
            lowPowerOscEnable <= 1'b1;
        else
            lowPowerOscEnable <= chain.lpSelect & run
                                 & ~clockControl[CTRL_OSC_OFF];
    end
endmodule
`default_nettype wire

// ### design/rtc_pkg.sv
// Shared constants for the real-time clock block
package rtc_pkg;
    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 6;
    localparam int          DATA_W       = 32;
    localparam logic [5:0]  OFS_CTRL     = 6'h00;
    localparam logic [5:0]  OFS_RELOAD   = 6'h04;
    localparam logic [5:0]  OFS_TIME     = 6'h08;
    localparam logic [5:0]  OFS_ALARM    = 6'h0C;
    localparam logic [5:0]  OFS_CYCLE_N  = 6'h10;
    localparam logic [5:0]  OFS_LONG_LO  = 6'h14;
    localparam logic [5:0]  OFS_STATUS   = 6'h18;
    localparam logic [5:0]  OFS_CLEAR    = 6'h1C;
    localparam logic [5:0]  OFS_IRQ_EN   = 6'h20;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int          CTRL_W           = 7;
    localparam int          CTRL_RUN         = 0;
    localparam int          CTRL_OSC_OFF     = 1;
    localparam int          CTRL_RUN_SLEEP   = 2;
    localparam int          CTRL_ROUTE_TICK  = 3;
    localparam int          CTRL_ROUTE_ALARM = 4;
    localparam int          CTRL_ROUTE_CYCLE = 5;
    localparam int          CTRL_WAKE        = 6;
    localparam int          CTRL_SRC_LP      = 8;
    localparam int          CTRL_DETECTED    = 9;
    localparam logic [6:0]  CTRL_RESET       = 7'h01;
    // ------------------------------------------------------------
    // Event bits
    // ------------------------------------------------------------
    localparam int          EV_W     = 3;
    localparam int          EV_TICK  = 0;
    localparam int          EV_ALARM = 1;
    localparam int          EV_CYCLE = 2;
    // ------------------------------------------------------------
    // Counter chain
    // ------------------------------------------------------------
    localparam int          PRE_W        = 6;
    localparam int          DIV_W        = 20;
    localparam int          TIME_W       = 32;
    localparam logic [19:0] RELOAD_RESET = 20'hBEBC1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ         = 50;
    localparam int          DETECT_TIME_US  = 250;
    localparam int          DETECT_CYCLES   = DETECT_TIME_US * CLK_MHZ;
    localparam int          DETECT_EDGES    = 4;
endpackage

// ### design/rtc_chain_if.sv
// Carrier between control, source detector and tick chain
`timescale 1ns/1ps
`default_nettype none
interface rtc_chain_if;
    logic        countEn;
    logic [19:0] reload;
    logic        lpSelect;
    logic        detectDone;
    logic        lpEdge;
    logic        tick;
    logic [5:0]  preValue;
    logic [19:0] divValue;
    modport ctrl   (output countEn, reload,
                    input  lpSelect, detectDone, tick, preValue, divValue);
    modport detect (output lpSelect, detectDone, lpEdge);
    modport chain  (input  countEn, reload, lpSelect, lpEdge,
                    output tick, preValue, divValue);
endinterface
`default_nettype wire

// ### design/rtc_osc_detect.sv
// Low-power oscillator presence detector and source selector
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_detect
    import rtc_pkg::*;
#(
    parameter int DETECT_LEN = DETECT_CYCLES
)(
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    input  wire logic   lowPowerOscIn,
    rtc_chain_if.detect chain
);
    logic        syncA;
    logic        syncB;
    logic        syncC;
    logic [15:0] window;
    logic [2:0]  edges;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            syncC <= 1'b0;
        end else begin
            syncA <= lowPowerOscIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) chain.lpEdge <= 1'b0;
        else        chain.lpEdge <= syncB & ~syncC;
    end

    // ------------------------------------------------------------
    // Detection window, restarted by every reset
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            window           <= 16'h0000;
            edges            <= 3'h0;
            chain.detectDone <= 1'b0;
            chain.lpSelect   <= 1'b0;
        end else if (!chain.detectDone) begin
            window <= window + 16'h0001;
            if (syncB & ~syncC && edges != 3'h7)
                edges <= edges + 3'h1;
            if (window == 16'(DETECT_LEN - 1)) begin
                chain.detectDone <= 1'b1;
                chain.lpSelect   <= (edges >= 3'(DETECT_EDGES));
            end
        end
    end
endmodule
`default_nettype wire

// ### design/rtc_tick_chain.sv
// Fixed divide-by-64 stage and reloadable tick divider
`timescale 1ns/1ps
`default_nettype none
module rtc_tick_chain
    import rtc_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    rtc_chain_if.chain chain
);
    logic srcPulse;
    logic preWrap;

    // Low-power source steps on synced edges, main source every cycle
    assign srcPulse = chain.countEn & (chain.lpSelect ? chain.lpEdge : 1'b1);
    assign preWrap  = srcPulse & (chain.preValue == 6'h3F);

    always_ff @(posedge sys_clk) begin
        if (!rst_n)        chain.preValue <= 6'h00;
        else if (srcPulse) chain.preValue <= chain.preValue + 6'h01;
    end

    // ------------------------------------------------------------
    // Divider: counts down, reloads at period end
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chain.divValue <= RELOAD_RESET;
            chain.tick     <= 1'b0;
        end else begin
            chain.tick <= 1'b0;
            if (preWrap) begin
                if (chain.divValue == 20'h00000) begin
                    // Reload sampled only here, so a new value waits
                    chain.divValue <= chain.reload;
                    chain.tick     <= 1'b1;
                end else begin
                    chain.divValue <= chain.divValue - 20'h00001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/rtc_timekeeper_alarm_asserts.sv
// Port-level checks for the real-time clock block
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper_alarm_asserts
    import rtc_pkg::*;
#(
    parameter int DETECT_LEN = DETECT_CYCLES
)(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [5:0]  avAddress,
    input wire logic        avRead,
    input wire logic        avWrite,
    input wire logic [31:0] avWriteData,
    input wire logic [31:0] avReadData,
    input wire logic        avWaitrequest,
    input wire logic        lowPowerOscIn,
    input wire logic        powerDown,
    input wire logic        mainOscEnable,
    input wire logic        lowPowerOscEnable,
    input wire logic        extIntTick,
    input wire logic        extIntCyclic,
    input wire logic        extIntAlarm,
    input wire logic        wakeRequest,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    bus_one_wait_a: assert property ((avRead || avWrite) && avWaitrequest |=> !avWaitrequest)
        else $error("bus request not answered after one wait state");
    bus_single_a: assert property (!avWaitrequest |=> avWaitrequest)
        else $error("answer lasted more than one cycle");
    read_idle_a: assert property (avWaitrequest |-> avReadData == 32'h0)
        else $error("read data not zero outside an answer");
    // ----------------------------------------
    // Events and wake
    // ----------------------------------------
    // Ticks are at least 64 cycles apart, so a pulse stands alone
    tick_pulse_a: assert property (extIntTick |=> !extIntTick [*8])
        else $error("tick line not a single pulse");
    alarm_pulse_a: assert property (extIntAlarm |=> !extIntAlarm)
        else $error("alarm line held high");
    wake_clear_a: assert property (!powerDown |=> !wakeRequest)
        else $error("wake request outside power-down");
    wake_rise_a: assert property ($rose(wakeRequest) |-> $past(powerDown))
        else $error("wake request raised while awake");
    // ----------------------------------------
    // Oscillators
    // ----------------------------------------
    osc_awake_a: assert property (!powerDown |=> mainOscEnable && lowPowerOscEnable)
        else $error("oscillator stopped while awake");
    osc_sleep_a: assert property (powerDown |=> !(mainOscEnable && lowPowerOscEnable))
        else $error("both oscillators kept in power-down");
endmodule
bind rtc_timekeeper_alarm rtc_timekeeper_alarm_asserts #(.DETECT_LEN(DETECT_LEN)) checks (
    .sys_clk(sys_clk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWriteData(avWriteData), .avReadData(avReadData),
    .avWaitrequest(avWaitrequest), .lowPowerOscIn(lowPowerOscIn), .powerDown(powerDown),
    .mainOscEnable(mainOscEnable), .lowPowerOscEnable(lowPowerOscEnable),
    .extIntTick(extIntTick), .extIntCyclic(extIntCyclic), .extIntAlarm(extIntAlarm),
    .wakeRequest(wakeRequest), .irq(irq));
`default_nettype wire

// ### sim/rtc_osc_model.sv
// Behavioural low-power crystal at the oscillator pin
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
    parameter int HALF = 4
)(
    input  wire logic sys_clk,
    input  wire logic present,
    input  wire logic oscEnable,
    output logic      oscOut
);
    int count = 0;
    // Swings only while fitted and powered; a stopped crystal rests low
    always @(posedge sys_clk) begin
        if (present && oscEnable) begin
            count <= (count == HALF - 1) ? 0 : count + 1;
            if (count == HALF - 1) oscOut <= ~oscOut;
        end else begin
            count  <= 0;
            oscOut <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### sim/rtc_timekeeper_alarm_test.sv
// Self-checking bench for the real-time clock block
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper_alarm_test;
    import rtc_pkg::*;
    logic        sys_clk, rst_n, avRead, avWrite, powerDown, present, lowPowerOscIn;
    logic [5:0]  avAddress;
    logic [31:0] avWriteData, avReadData, d, d2, t, seed;
    logic        avWaitrequest, mainOscEnable, lowPowerOscEnable;
    logic        extIntTick, extIntCyclic, extIntAlarm, wakeRequest, irq;
    int          errors, testsRun, cyc, c0, alarmCount, i;
    logic [5:0]  rstOfs [7] = '{OFS_CTRL, OFS_RELOAD, OFS_ALARM, OFS_IRQ_EN, OFS_STATUS,
                                OFS_CLEAR, 6'h24};
    logic [31:0] rstVal [7] = '{{25'h0, CTRL_RESET}, {12'h0, RELOAD_RESET}, 32'hFFFFFFFF,
                                32'h0, 32'h0, 32'h0, 32'h0};
    rtc_timekeeper_alarm #(.DETECT_LEN(64)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
        .avWrite(avWrite), .avWriteData(avWriteData), .avReadData(avReadData),
        .avWaitrequest(avWaitrequest), .lowPowerOscIn(lowPowerOscIn), .powerDown(powerDown),
        .mainOscEnable(mainOscEnable), .lowPowerOscEnable(lowPowerOscEnable),
        .extIntTick(extIntTick), .extIntCyclic(extIntCyclic), .extIntAlarm(extIntAlarm),
        .wakeRequest(wakeRequest), .irq(irq));
    rtc_osc_model crystal (.sys_clk(sys_clk), .present(present),
        .oscEnable(lowPowerOscEnable), .oscOut(lowPowerOscIn));
    // ----------------------------------------
    // Clock, cycle count, event monitor
    // ----------------------------------------
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    always @(posedge sys_clk) if (extIntAlarm === 1'b1) alarmCount <= alarmCount + 1;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Waits for the answer edge; the slave's speed is not assumed
    task automatic waitAnswer();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avWaitrequest !== 1'b0 && n < 40);
        if (n >= 40) checkVal(32'h0, 32'h1, "bus answer timeout");
    endtask
    task automatic busWrite(input logic [5:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        avAddress <= a;
        avWriteData <= v;
        avWrite <= 1'b1;
        waitAnswer();
        avWrite <= 1'b0;
    endtask
    task automatic busRead(input logic [5:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        avAddress <= a;
        avRead <= 1'b1;
        waitAnswer();
        v = avReadData;
        avRead <= 1'b0;
    endtask
    // Source steps elapsed since the divider started, from a long-timer sample
    function automatic int steps(input logic [31:0] v);
        return (int'(RELOAD_RESET) - int'(v[25:6])) * 64 + int'(v[5:0]);
    endfunction
    // Two long-timer samples, g idle cycles between the reads; d2 minus d in steps
    task automatic stepPair(input int g, output int delta, output int gap);
        busRead(OFS_LONG_LO, d);
        c0 = cyc;
        idle(g);
        busRead(OFS_LONG_LO, d2);
        delta = steps(d2) - steps(d);
        gap = cyc - c0;
    endtask
    task automatic fireAlarm(input logic [31:0] v);
        busWrite(OFS_ALARM, v);
        busWrite(OFS_TIME, v - 32'h1);
        busWrite(OFS_TIME, v);
        idle(4);
    endtask
    task automatic tallyAndFinish();
        $display("compares %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        errors++;
        $display("Error at %0t: run did not finish", $time);
        tallyAndFinish();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int dl, gp;
        seed = 32'h5E43;
        {rst_n, avRead, avWrite, powerDown, present, avAddress, avWriteData} = '0;
        {errors, testsRun, cyc, alarmCount} = '0;
        idle(6);
        rst_n <= 1'b1;
        busWrite(6'h24, 32'hFFFFFFFF);
        for (i = 0; i < 7; i++) begin
            busRead(rstOfs[i], d);
            checkVal(d, rstVal[i], "reset value");
        end
        $display("test reset values done");
        idle(80);
        busRead(OFS_CTRL, d);
        checkVal(d, 32'h201, "main source chosen");
        for (i = 0; i < 3; i++) begin
            t = $random(seed) & 32'hFFFFF;
            busRead(OFS_LONG_LO, d);
            c0 = cyc;
            busWrite(OFS_RELOAD, t);
            idle(i * 37);
            busRead(OFS_LONG_LO, d2);
            checkVal(steps(d2) - steps(d), cyc - c0, "steps across reload write");
            busRead(OFS_RELOAD, d);
            checkVal(d, t, "reload readback");
        end
        $display("test divider chain done");
        busWrite(OFS_CTRL, 32'h11);
        busWrite(OFS_IRQ_EN, 32'h2);
        for (i = 0; i < 3; i++) begin
            t = $random(seed);
            alarmCount = 0;
            fireAlarm(t);
            checkVal(alarmCount, 1, "alarm pulses");
            checkVal({extIntTick, extIntCyclic}, 2'b00, "no tick in first period");
            busRead(OFS_TIME, d);
            checkVal(d, t, "time readback");
            busRead(OFS_STATUS, d);
            checkVal(d, 32'h2, "alarm status");
            checkVal(irq, 1'b1, "irq raised");
            busWrite(OFS_IRQ_EN, 32'h0);
            idle(3);
            checkVal(irq, 1'b0, "irq masked");
            busWrite(OFS_IRQ_EN, 32'h2);
            busWrite(OFS_CLEAR, 32'h2);
            busRead(OFS_STATUS, d);
            checkVal(d, 32'h0, "status cleared");
            checkVal(irq, 1'b0, "irq after clear");
        end
        $display("test alarm done");
        busWrite(OFS_CTRL, 32'h45);
        powerDown <= 1'b1;
        fireAlarm($random(seed));
        checkVal(wakeRequest, 1'b1, "wake on alarm");
        checkVal(mainOscEnable, 1'b1, "main kept for counting");
        stepPair(20, dl, gp);
        checkVal(dl, gp, "counting in power-down");
        busWrite(OFS_CTRL, 32'h01);
        stepPair(20, dl, gp);
        checkVal(dl, 0, "stopped in power-down");
        busWrite(OFS_CTRL, 32'h03);
        idle(3);
        checkVal({mainOscEnable, lowPowerOscEnable}, 2'b00, "oscillator off bit");
        busWrite(OFS_CTRL, 32'h00);
        idle(3);
        checkVal({mainOscEnable, lowPowerOscEnable}, 2'b00, "disabled clock");
        powerDown <= 1'b0;
        idle(3);
        checkVal({wakeRequest, mainOscEnable, lowPowerOscEnable}, 3'b011, "awake");
        $display("test power-down done");
        rst_n <= 1'b0;
        present <= 1'b1;
        idle(6);
        rst_n <= 1'b1;
        idle(90);
        busRead(OFS_CTRL, d);
        checkVal(d, 32'h301, "low-power source chosen");
        powerDown <= 1'b1;
        busWrite(OFS_CTRL, 32'h05);
        idle(3);
        checkVal({mainOscEnable, lowPowerOscEnable}, 2'b01, "main off on 32k");
        stepPair(60, dl, gp);
        checkVal(dl > 0 && dl <= gp / 8 + 1, 1'b1, "steps follow crystal");
        $display("test low-power source done");
        tallyAndFinish();
    end
endmodule
`default_nettype wire
